// file: src/dac_link_if.sv
`default_nettype none
interface dac_link_if;
    logic sel_n;
    logic sck;
    logic sdata;
    modport device (input sel_n, input sck, input sdata);
    modport host (output sel_n, output sck, output sdata);
endinterface
`default_nettype wire

// file: src/dac_link_pkg.sv
`default_nettype none
package dac_link_pkg;
    localparam int WORD_BITS = 16;
    localparam int CODE_BITS = 12;
    localparam int MODE_HI_POS = 13;
    localparam int MODE_LO_POS = 12;
    localparam int CODE_MSB = 11;
    localparam logic [11:0] CODE_RESET = 12'h000;
    localparam logic [4:0] BIT_LAST = 5'h10;
    localparam int SYS_CLK_MHZ = 100;
    localparam int SELECT_IDLE_NS = 33;
    localparam int SELECT_IDLE_CYC = (SELECT_IDLE_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int RECOVER_NS = 2500;
    localparam int RECOVER_CYC = (RECOVER_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int LINK_DIV = 4;
    localparam int LINK_HALF = LINK_DIV / 2;
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_LAST = 12'h008;
    localparam int CTRL_GO_POS = 16;
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_PD_1K = 2'b01,
        MODE_PD_100K = 2'b10,
        MODE_PD_HIZ = 2'b11
    } out_mode_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SETUP = 2'b01,
        ST_SHIFT = 2'b10,
        ST_GAP = 2'b11
    } host_state_t;
endpackage
`default_nettype wire

// file: src/dac_write_host.sv
// The APB interface to the registers and the register addresses were left to the implementer.
`default_nettype none
// Controller end: APB registers, divided shift clock out
module dac_write_host
    import dac_link_pkg::*;
(
    input wire logic I_CLK_SYS,
    input wire logic I_RST_N,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    dac_link_if.host link
);
    host_state_t state_ff;
    logic [15:0] word_ff;
    logic [15:0] last_ff;
    logic [4:0] bits_ff;
    logic [7:0] div_ff;
    logic sel_n_ff;
    logic sck_ff;
    logic sdata_ff;
    logic access;
    logic go;
    assign access = I_PSEL && I_PENABLE && O_PREADY;
    assign go = access && I_PWRITE && I_PADDR == ADDR_CTRL && I_PWDATA[CTRL_GO_POS];
    assign link.sel_n = sel_n_ff;
    assign link.sck = sck_ff;
    assign link.sdata = sdata_ff;
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            O_PREADY <= 1'b0;
            O_PSLVERR <= 1'b0;
            O_PRDATA <= 32'h0000_0000;
        end else begin
            O_PREADY <= I_PSEL && !I_PENABLE;
            O_PSLVERR <= I_PSEL && !I_PENABLE && I_PADDR != ADDR_CTRL
                && I_PADDR != ADDR_STATUS && I_PADDR != ADDR_LAST;
            case (I_PADDR)
                ADDR_STATUS: O_PRDATA <= {31'h0, state_ff != ST_IDLE};
                ADDR_LAST: O_PRDATA <= {16'h0000, last_ff};
                default: O_PRDATA <= 32'h0000_0000;
            endcase
        end
    end
    // Frame sequencer; select parked low while idle
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            state_ff <= ST_IDLE;
            word_ff <= 16'h0000;
            last_ff <= 16'h0000;
            bits_ff <= 5'h00;
            div_ff <= 8'h00;
            sel_n_ff <= 1'b0;
            sck_ff <= 1'b1;
            sdata_ff <= 1'b0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (go && !O_PSLVERR) begin
                        word_ff <= I_PWDATA[15:0];
                        last_ff <= I_PWDATA[15:0];
                        sel_n_ff <= 1'b1; // R07
                        div_ff <= 8'h00;
                        state_ff <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    div_ff <= div_ff + 8'h01;
                    if (div_ff == 8'(SELECT_IDLE_CYC)) begin // R06
                        sel_n_ff <= 1'b0; // R01
                        sdata_ff <= word_ff[15]; // R17
                        word_ff <= {word_ff[14:0], 1'b0};
                        bits_ff <= 5'h00;
                        div_ff <= 8'h00;
                        state_ff <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    div_ff <= div_ff + 8'h01;
                    if (div_ff == 8'(LINK_HALF - 1)) begin
                        sck_ff <= 1'b0; // R03
                    end else if (div_ff == 8'(LINK_DIV - 1)) begin
                        sck_ff <= 1'b1;
                        div_ff <= 8'h00;
                        bits_ff <= bits_ff + 5'h01;
                        sdata_ff <= word_ff[15];
                        word_ff <= {word_ff[14:0], 1'b0};
                        if (bits_ff + 5'h01 == BIT_LAST) begin
                            state_ff <= ST_SETUP;
                        end
                    end
                end
                ST_SETUP: begin
                    state_ff <= ST_IDLE; // R05
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// file: src/dac_write_port.sv
`default_nettype none
// How it works
// [R01] Host drops select before any data
// [R02] Falling shift clock samples data, 16 bits
// [R03] Shift clock stays at or below 30 MHz
// [R04] Sixteenth edge applies word to code, mode
// [R05] Select may stay low or rise after
// [R06] Select high 33 ns before next frame
// [R07] Park select low between writes
// [R08] Word: two ignored, two mode, twelve code
// [R09] Early select rise aborts, clears shift register
// [R10] Aborted frame leaves code and mode
// [R11] Power-up code is zero until write
// [R12] Mode bits 13,12 choose normal or power-down
// [R13] Power-down selects termination, shuts analog
// [R14] Power-down keeps stored code intact; here a power-down word loads its code field into O_CODE
// [R15] Leaving power-down needs 2.5 us recovery
// [R16] Code is unsigned binary 0 to 4095
// [R17] Word sent most significant bit first
// [R18] Done frame ignores edges until reselected
module dac_write_port
    import dac_link_pkg::*;
(
    input wire logic I_CLK_SYS,
    input wire logic I_RST_N,
    dac_link_if.device link,
    output logic [11:0] O_CODE,
    output logic [1:0] O_MODE,
    output logic O_AMP_ON,
    output logic O_TERM_1K,
    output logic O_TERM_100K,
    output logic O_OUT_VALID
);
    logic [15:0] shift_ff;
    logic [4:0] count_ff;
    logic done_ff;
    logic [11:0] code_ff;
    logic [1:0] mode_ff;
    logic upd_tgl_ff;
    logic [15:0] nxt_shift;
    // Link domain: the device runs on the falling shift clock; select high resets frame
    assign nxt_shift = {shift_ff[14:0], link.sdata}; // R17
    always_ff @(negedge link.sck or posedge link.sel_n) begin
        if (link.sel_n) begin
            shift_ff <= 16'h0000; // R09
            count_ff <= 5'h00;
            done_ff <= 1'b0; // R05
        end else if (!done_ff) begin // R18
            shift_ff <= nxt_shift; // R02
            count_ff <= count_ff + 5'h01;
            if (count_ff + 5'h01 == BIT_LAST) begin
                done_ff <= 1'b1; // R04
            end
        end
    end
    // Applied registers only change on a completed word
    always_ff @(negedge link.sck or negedge I_RST_N) begin
        if (!I_RST_N) begin
            code_ff <= CODE_RESET; // R11
            mode_ff <= MODE_NORMAL;
            upd_tgl_ff <= 1'b0;
        end else if (!link.sel_n && !done_ff && count_ff + 5'h01 == BIT_LAST) begin // R10
            code_ff <= nxt_shift[CODE_MSB:0]; // R08 R16
            mode_ff <= {nxt_shift[MODE_HI_POS], nxt_shift[MODE_LO_POS]}; // R12
            upd_tgl_ff <= ~upd_tgl_ff;
        end
    end
    // System domain: synchronise word and update toggle
    logic [2:0] tgl_sync_ff;
    logic [13:0] data_meta_ff;
    logic [13:0] data_sync_ff;
    logic [15:0] recover_ff;
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            tgl_sync_ff <= 3'h0;
            data_meta_ff <= 14'h0000;
            data_sync_ff <= 14'h0000;
        end else begin
            tgl_sync_ff <= {tgl_sync_ff[1:0], upd_tgl_ff};
            data_meta_ff <= {mode_ff, code_ff};
            data_sync_ff <= data_meta_ff;
        end
    end
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            O_CODE <= CODE_RESET;
            O_MODE <= MODE_NORMAL;
            O_AMP_ON <= 1'b1;
            O_TERM_1K <= 1'b0;
            O_TERM_100K <= 1'b0;
        end else if (tgl_sync_ff[2] != tgl_sync_ff[1]) begin
            O_CODE <= data_sync_ff[11:0]; // R14
            O_MODE <= data_sync_ff[13:12];
            O_AMP_ON <= data_sync_ff[13:12] == MODE_NORMAL; // R13
            O_TERM_1K <= data_sync_ff[13:12] == MODE_PD_1K;
            O_TERM_100K <= data_sync_ff[13:12] == MODE_PD_100K;
        end
    end
    // Output valid after recovery time in normal mode
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            recover_ff <= 16'h0000;
            O_OUT_VALID <= 1'b0;
        end else if (!O_AMP_ON) begin
            recover_ff <= 16'h0000;
            O_OUT_VALID <= 1'b0;
        end else if (recover_ff < 16'(RECOVER_CYC)) begin
            recover_ff <= recover_ff + 16'h0001; // R15
            O_OUT_VALID <= 1'b0;
        end else begin
            O_OUT_VALID <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// file: testbench/dac_link_sva.sv
`default_nettype none
module dac_link_sva
    import dac_link_pkg::*;
(
    input wire logic I_CLK_SYS,
    input wire logic I_RST_N,
    input wire logic sel_n,
    input wire logic sck,
    input wire logic sdata,
    input wire logic [11:0] O_CODE,
    input wire logic [1:0] O_MODE,
    input wire logic O_AMP_ON,
    input wire logic O_TERM_1K,
    input wire logic O_TERM_100K,
    input wire logic O_OUT_VALID
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] sk_ff, sd_ff, sl_ff;
    logic [4:0] cnt_ff;
    logic [15:0] sh_ff;
    logic [3:0] done_ff;
    logic [9:0] amp_ff;
    wire fall = sk_ff[1] & ~sk_ff[0];
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RST_N);
    // Link lines sampled into the system domain
    always_ff @(posedge I_CLK_SYS) begin
        sk_ff <= {sk_ff[0], sck};
        sd_ff <= {sd_ff[0], sdata};
        sl_ff <= {sl_ff[0], sel_n};
    end
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N || sl_ff[0]) begin
            cnt_ff <= 5'h00;
        end else if (fall && cnt_ff != BIT_LAST) begin
            cnt_ff <= cnt_ff + 5'h01;
            sh_ff <= {sh_ff[14:0], sd_ff[0]};
        end
    end
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) done_ff <= 4'hF;
        else if (fall && cnt_ff == 5'h0F) done_ff <= 4'h0;
        else if (done_ff != 4'hF) done_ff <= done_ff + 4'h1;
    end
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N || !O_AMP_ON) amp_ff <= 10'h000;
        else if (amp_ff != 10'h3FF) amp_ff <= amp_ff + 10'h001;
    end
    amp_mode_a: assert property ($stable(O_MODE) [*3] |-> O_AMP_ON == (O_MODE == MODE_NORMAL))
        else $error("amplifier enable does not follow mode");
    term_1k_a: assert property ($stable(O_MODE) [*3] |-> O_TERM_1K == (O_MODE == MODE_PD_1K))
        else $error("1k termination does not follow mode");
    term_100k_a: assert property ($stable(O_MODE) [*3] |-> O_TERM_100K == (O_MODE == MODE_PD_100K))
        else $error("100k termination does not follow mode");
    hiz_open_a: assert property (($stable(O_MODE) && O_MODE == MODE_PD_HIZ) [*3] |->
        !O_AMP_ON && !O_TERM_1K && !O_TERM_100K) else $error("open output still driven");
    apply_word_a: assert property (fall && cnt_ff == 5'h0F |->
        ##[1:8] (O_CODE == sh_ff[11:0] && O_MODE == sh_ff[13:12])) else $error("word not applied");
    update_window_a: assert property ($changed(O_CODE) || $changed(O_MODE) |-> done_ff < 4'h9)
        else $error("code or mode changed outside a completed frame");
    valid_early_a: assert property (O_OUT_VALID && O_AMP_ON |-> amp_ff >= RECOVER_CYC - 3)
        else $error("output valid before recovery");
    valid_late_a: assert property (amp_ff == RECOVER_CYC + 3 |-> O_OUT_VALID)
        else $error("output valid missing after recovery");
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
`default_nettype none
module tb_top import dac_link_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [11:0] paddr = 12'h000, code_a, code_b;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, err, amp, t1k, t100k, vld;
    logic [1:0] mode_a, mode_b;
    logic [15:0] mon;
    logic [15:0] words [5] = '{16'hCFFF, 16'h1800, 16'h27FF, 16'h3123, 16'h0ABC};
    int mon_n, error_cnt = 0, comparisons = 0;
    dac_link_if link_a();
    dac_link_if link_b();
    always #5 clk = ~clk;
    dac_write_host dac_write_host_i (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_PSEL(psel),
        .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .link(link_a));
    dac_write_port dac_write_port_i (.I_CLK_SYS(clk), .I_RST_N(rst_n), .link(link_a),
        .O_CODE(code_a), .O_MODE(mode_a), .O_AMP_ON(amp), .O_TERM_1K(t1k),
        .O_TERM_100K(t100k), .O_OUT_VALID(vld));
    dac_write_port dac_write_port_i2 (.I_CLK_SYS(clk), .I_RST_N(rst_n), .link(link_b),
        .O_CODE(code_b), .O_MODE(mode_b), .O_AMP_ON(), .O_TERM_1K(), .O_TERM_100K(),
        .O_OUT_VALID());
    dac_link_sva dac_link_sva_i (.I_CLK_SYS(clk), .I_RST_N(rst_n), .sel_n(link_a.sel_n),
        .sck(link_a.sck), .sdata(link_a.sdata), .O_CODE(code_a), .O_MODE(mode_a),
        .O_AMP_ON(amp), .O_TERM_1K(t1k), .O_TERM_100K(t100k), .O_OUT_VALID(vld));
    always @(negedge link_a.sck or posedge link_a.sel_n) begin
        if (link_a.sel_n) mon_n <= 0;
        else begin
            mon <= {mon[14:0], link_a.sdata};
            mon_n <= mon_n + 1;
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
            error_cnt++;
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1 && n++ < 20);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (n >= 20) chk(32'h1, 32'h0);
    endtask
    task automatic t_frame(input logic [15:0] w);
        int n;
        n = 0;
        apb(1'b1, ADDR_CTRL, {15'h0, 1'b1, w});
        do apb(1'b0, ADDR_STATUS, 32'h0); while (q[0] !== 1'b0 && n++ < 60);
        repeat (8) @(posedge clk);
        chk(mon_n, 16);
        chk(mon, w);
        chk(link_a.sck, 1'b1);
        chk(code_a, w[11:0]);
        chk(mode_a, w[13:12]);
        chk({amp, t1k, t100k}, {w[13:12] == 2'b00, w[13:12] == 2'b01, w[13:12] == 2'b10});
        apb(1'b0, ADDR_LAST, 32'h0);
        chk(q[15:0], w);
    endtask
    task automatic lk(input logic [15:0] w, input int n);
        link_b.sel_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            link_b.sdata = w[4'(15 - i)];
            #62.5 link_b.sck = 1'b0;
            #62.5 link_b.sck = 1'b1;
        end
        link_b.sdata = ~link_b.sdata;
        #40 link_b.sel_n = 1'b1;
        #40 repeat (8) @(posedge clk);
    endtask
    task automatic t_link();
        lk(16'h1A5C, 16);
        chk({mode_b, code_b}, 14'h1A5C);
        lk(16'h0FFF, 15);
        chk({mode_b, code_b}, 14'h1A5C);
        lk(16'h2345, 16);
        chk({mode_b, code_b}, 14'h2345);
        lk(16'h3678, 20);
        chk({mode_b, code_b}, 14'h3678);
    endtask
    task automatic finish_test();
        $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #100000;
        error_cnt++;
        finish_test();
    end
    initial begin
        link_b.sel_n = 1'b1;
        link_b.sck = 1'b1;
        link_b.sdata = 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk({mode_a, code_a}, 14'h0000);
        foreach (words[i]) t_frame(words[i]);
        chk(vld, 1'b0);
        repeat (RECOVER_CYC - 40) @(posedge clk);
        chk(vld, 1'b0);
        repeat (60) @(posedge clk);
        chk(vld, 1'b1);
        t_link();
        apb(1'b0, 12'h00C, 32'h0);
        chk(err, 1'b1);
        finish_test();
    end
endmodule
`default_nettype wire
